// file: memory_select_protect_ctrl_tb_top.sv
// Self-checking testbench of the memory select and protection controller
`timescale 1ns/1ps
module memory_select_protect_ctrl_tb_top;
  import msp_pkg::*;
`define CHK(a, e, m) begin checks++; if ((a) !== (e)) begin err_total++; \
  $display("wrong value at %0t: %s", $time, m); end end

  // ==================================================================
  // Signals
  logic clock, arst_n, wr_stb, rd_stb, program_fetch_strobe, security_flag;
  logic [15:0] addr;
  logic [7:0] wdata, map_boot, reg_rdata;
  logic [3:0] cfg_prim_prot, tp_prim_prot;
  logic [1:0] cfg_sec_prot, tp_sec_prot;
  logic tp_prot_we, fl_busy, fl_error, fl_abort, fl_read_mode, reg_rvalid, err_mode;
  msp_sel_s decode_sel, mem_en;
  msp_fcmd_s fl_cmd;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  localparam msp_sel_s REG_S = 9'h002;
  msp_op_e ops [3] = '{MSP_OP_PGM, MSP_OP_BULK, MSP_OP_SECT};
  // Same-level selects never overlap in these rows
  logic [27:0] mtab [17] = '{
    {9'h024, 8'h00, 2'b10, 9'h004},
    {9'h028, 8'h18, 2'b10, 9'h008},
    {9'h028, 8'h10, 2'b10, 9'h000},
    {9'h040, 8'h0c, 2'b01, 9'h040},
    {9'h040, 8'h0c, 2'b10, 9'h000},
    {9'h010, 8'h0c, 2'b10, 9'h010},
    {9'h080, 8'h14, 2'b10, 9'h080},
    {9'h080, 8'h14, 2'b01, 9'h080},
    {9'h004, 8'h00, 2'b01, 9'h000},
    {9'h004, 8'h01, 2'b01, 9'h004},
    {9'h001, 8'h00, 2'b10, 9'h000},
    {9'h001, 8'h80, 2'b10, 9'h001},
    {9'h000, 8'hff, 2'b10, 9'h000},
    {9'h010, 8'h08, 2'b01, 9'h000},
    {9'h040, 8'h10, 2'b10, 9'h040},
    {9'h002, 8'h00, 2'b10, 9'h002},
    {9'h004, 8'hff, 2'b00, 9'h000}
  };

  // ==================================================================
  // Design and flash model
  msp_ctrl i_msp_ctrl (.clock(clock), .arst_n(arst_n), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .program_fetch_strobe(program_fetch_strobe),
    .decode_sel(decode_sel), .map_boot(map_boot), .cfg_prim_prot(cfg_prim_prot),
    .cfg_sec_prot(cfg_sec_prot), .security_flag(security_flag), .tp_prot_we(tp_prot_we),
    .tp_prim_prot(tp_prim_prot), .tp_sec_prot(tp_sec_prot), .fl_busy(fl_busy),
    .fl_error(fl_error), .mem_en(mem_en), .fl_cmd(fl_cmd), .fl_abort(fl_abort),
    .fl_read_mode(fl_read_mode), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  msp_flash_model #(.BUSY_LAT(12)) i_msp_flash_model (.clock(clock), .arst_n(arst_n),
    .fl_cmd(fl_cmd), .fl_abort(fl_abort), .err_mode(err_mode), .fl_busy(fl_busy),
    .fl_error(fl_error));

  // ==================================================================
  // Access tasks
  function automatic msp_sel_s psel(input int i, input logic sec);
    msp_sel_s s;
    s = '0;
    if (sec) s.secondary_sector_selects[i] = 1'b1;
    else s.primary_sector_selects[i] = 1'b1;
    return s;
  endfunction

  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d, input msp_sel_s s);
    @(posedge clock);
    #1;
    addr = a;
    wdata = d;
    decode_sel = s;
    wr_stb = w;
    rd_stb = !w;
    @(posedge clock);
    #1;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    decode_sel = '0;
  endtask

  task automatic reg_rd(input logic [7:0] ofs, input logic [7:0] exp, input string m);
    bus(1'b0, {8'h00, ofs}, 8'h00, REG_S);
    `CHK(reg_rvalid, 1'b1, "read valid")
    `CHK(reg_rdata, exp, m)
  endtask

  task automatic fl_wr(input logic [11:0] a, input logic [7:0] d, input msp_sel_s s);
    bus(1'b1, {4'h0, a}, d, s);
  endtask

  task automatic unlock(input msp_sel_s s);
    fl_wr(MSP_UNLK_ADDR1, MSP_UNLK_DATA1, s);
    fl_wr(MSP_UNLK_ADDR2, MSP_UNLK_DATA2, s);
  endtask

  task automatic start_op(input msp_op_e op, input msp_sel_s s);
    unlock(s);
    if (op == MSP_OP_PGM) begin
      fl_wr(MSP_UNLK_ADDR1, MSP_CMD_PGM, s);
      fl_wr(12'h123, 8'h5a, s);
    end else begin
      fl_wr(MSP_UNLK_ADDR1, MSP_CMD_ERASE, s);
      unlock(s);
      fl_wr(12'h000, (op == MSP_OP_SECT) ? MSP_CMD_SECT : MSP_CMD_BULK, s);
    end
  endtask

  // Bounded wait; a flash that never returns to read mode shows as a mismatch
  task automatic wait_ready();
    for (int i = 0; i < 100 && fl_read_mode !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    `CHK(fl_read_mode, 1'b1, "read mode")
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ==================================================================
  // Clock and timeout
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      give_verdict();
    end
  end

  // ==================================================================
  // Test sequence
  initial begin
    arst_n = 1'b0;
    {addr, wdata, wr_stb, rd_stb, program_fetch_strobe, decode_sel} = '0;
    map_boot = 8'h7d;
    cfg_prim_prot = 4'b0010;
    cfg_sec_prot = 2'b01;
    security_flag = 1'b1;
    {tp_prot_we, tp_prim_prot, tp_sec_prot, err_mode} = '0;
    repeat (4) @(posedge clock);
    #1;
    arst_n = 1'b1;
    @(posedge clock);
    reg_rd(MSP_OFS_PRIM_PROT, 8'h02, "primary status");
    reg_rd(MSP_OFS_SEC_PROT, 8'h81, "secondary status");
    security_flag = 1'b0;
    reg_rd(MSP_OFS_SEC_PROT, 8'h01, "security clear");
    reg_rd(MSP_OFS_SPACE_MAP, 8'h1d, "boot map");
    reg_rd(8'h55, 8'h00, "unmapped read");
    bus(1'b1, {8'h00, MSP_OFS_SPACE_MAP}, 8'hff, REG_S);
    reg_rd(MSP_OFS_SPACE_MAP, 8'h9f, "map write");
    bus(1'b1, {8'h00, MSP_OFS_PRIM_PROT}, 8'hff, REG_S);
    reg_rd(MSP_OFS_PRIM_PROT, 8'h02, "status after write");
    $display("test registers done");

    for (int i = 0; i < 17; i++) begin
      bus(1'b1, {8'h00, MSP_OFS_SPACE_MAP}, mtab[i][18:11], REG_S);
      @(posedge clock);
      #1;
      decode_sel = mtab[i][27:19];
      {rd_stb, program_fetch_strobe} = mtab[i][10:9];
      #1;
      `CHK(mem_en, mtab[i][8:0], "memory enable")
      @(posedge clock);
      #1;
      decode_sel = '0;
      {rd_stb, program_fetch_strobe} = 2'b00;
    end
    $display("test select priority done");

    for (int k = 0; k < 3; k += 2) begin
      start_op(ops[k], psel(1, 1'b0));
      `CHK(fl_cmd.start, 1'b0, "protected primary")
    end
    start_op(MSP_OP_PGM, psel(0, 1'b1));
    `CHK(fl_cmd.start, 1'b0, "protected secondary")
    wait_ready();
    @(posedge clock);
    #1;
    tp_prot_we = 1'b1;
    @(posedge clock);
    #1;
    tp_prot_we = 1'b0;
    reg_rd(MSP_OFS_PRIM_PROT, 8'h00, "cleared by port");
    start_op(MSP_OP_PGM, psel(1, 1'b0));
    `CHK(fl_cmd.start, 1'b1, "unprotected start")
    wait_ready();
    $display("test protection done");

    for (int k = 0; k < 3; k++) begin
      start_op(ops[k], psel(0, 1'b0));
      `CHK(fl_cmd.start, 1'b1, "command start")
      `CHK(fl_cmd.op, ops[k], "command kind")
      `CHK(fl_cmd.prim, (ops[k] == MSP_OP_BULK) ? 4'hf : 4'h1, "command sectors")
      @(posedge clock);
      fl_wr(12'h000, MSP_CMD_RESET, psel(0, 1'b0));
      `CHK(fl_abort, ops[k] == MSP_OP_SECT, "reset during busy")
      `CHK(fl_read_mode, 1'b0, "busy mode")
      wait_ready();
      `CHK(fl_abort, 1'b0, "abort released")
    end
    $display("test reset during busy done");

    err_mode = 1'b1;
    start_op(MSP_OP_PGM, psel(0, 1'b0));
    for (int i = 0; i < 100 && fl_error !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    @(posedge clock);
    #1;
    err_mode = 1'b0;
    `CHK(fl_read_mode, 1'b0, "error holds")
    unlock(psel(0, 1'b0));
    fl_wr(12'h000, MSP_CMD_RESET, psel(0, 1'b0));
    wait_ready();
    $display("test error recovery done");
    give_verdict();
  end
endmodule

// file: msp_ctrl.sv
// Memory select, sector protection and flash command controller
//
// What this block does
// RULE_01: Each primary and secondary sector has its own program/erase protection.
// RULE_02: Program or erase aimed at a protected sector is dropped silently.
// RULE_03: Reading a protected sector returns stored data as normal.
// RULE_04: Protection changes only via the test/programming port.
// RULE_05: MCU reads protection bits; MCU writes to them do nothing.
// RULE_06: Flash reset is one write, optionally after the two unlock writes.
// RULE_07: Software issues reset after ID/status reads or after an error.
// RULE_08: Reset returns flash to read mode; after error within milliseconds.
// RULE_09: Reset is ignored during byte program or bulk erase.
// RULE_10: Reset during sector erase aborts it and returns to read mode.
// RULE_11: Primary status register shows sectors 3..0 in bits 3..0.
// RULE_12: Secondary status shows sectors 1..0 in bits 1..0, security in bit 7.
// RULE_13: SRAM is enabled only while its select is high.
// RULE_14: Software decode must not overlap same-level selects.
// RULE_15: Secondary sector wins over a primary sector on overlap.
// RULE_16: SRAM, registers and PIO win over any flash sector.
// RULE_17: Space map loads a boot value and is rewritable at run time.
// RULE_18: Space map bits gate PIO, data reads and program fetches.
// RULE_19: Separate-space operation uses space map value 0Ch.
// RULE_20: Bits 2 and 4 set put primary flash in both spaces.
// RULE_21: No select or a gated strobe drives no internal memory.
`timescale 1ns/1ps
module msp_ctrl
  import msp_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic program_fetch_strobe,
  input wire msp_pkg::msp_sel_s decode_sel,
  input wire logic [7:0] map_boot,
  input wire logic [MSP_PRIM_N-1:0] cfg_prim_prot,
  input wire logic [MSP_SEC_N-1:0] cfg_sec_prot,
  input wire logic security_flag,
  input wire logic tp_prot_we,
  input wire logic [MSP_PRIM_N-1:0] tp_prim_prot,
  input wire logic [MSP_SEC_N-1:0] tp_sec_prot,
  input wire logic fl_busy,
  input wire logic fl_error,
  output msp_pkg::msp_sel_s mem_en,
  output msp_pkg::msp_fcmd_s fl_cmd,
  output logic fl_abort,
  output logic fl_read_mode,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid
);
  import msp_pkg::*;

  msp_ctrl_s s_q;
  msp_ctrl_s s_d;
  msp_sel_s tgt;

  // ==================================================================
  // Select priority and strobe gating
  msp_route u_route (
    .sel(decode_sel),
    .space_map(s_q.map),
    .rd_stb(rd_stb),
    .program_fetch_strobe(program_fetch_strobe),
    .tgt(tgt),
    .mem_en(mem_en)
  );

  function automatic logic prot_hit(input msp_sel_s t, input logic [MSP_PRIM_N-1:0] pp,
                                    input logic [MSP_SEC_N-1:0] sp);
    prot_hit = (|(t.primary_sector_selects & pp)) | (|(t.secondary_sector_selects & sp));
  endfunction

  function automatic logic is_unlk(input logic [15:0] a, input logic [7:0] d,
                                   input logic [11:0] ua, input logic [7:0] ud);
    is_unlk = (a[11:0] == ua) && (d == ud);
  endfunction

  // ==================================================================
  // Decoded bus events and busy state
  logic fl_wr;
  logic reg_wr;
  logic reg_rd;
  logic rst_cmd;
  logic busy_st;

  always_comb begin
    fl_wr = wr_stb & ((|tgt.primary_sector_selects) | (|tgt.secondary_sector_selects));
    reg_wr = wr_stb & tgt.register_block_select;
    reg_rd = rd_stb & tgt.register_block_select;
    rst_cmd = fl_wr && (wdata == MSP_CMD_RESET);
    busy_st = (s_q.st == MSP_ST_BUSY_PGM) || (s_q.st == MSP_ST_BUSY_BULK) ||
              (s_q.st == MSP_ST_BUSY_SECT);
  end

  // ==================================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.cmd.start = 1'b0;
    s_d.rvalid = 1'b0;
    // Configuration levels are caught one edge after reset release
    if (!s_q.boot_done) begin
      s_d.boot_done = 1'b1;
      s_d.map = map_boot & MSP_MAP_RW_MASK; // RULE_17
      s_d.prim_prot = cfg_prim_prot; // RULE_01
      s_d.sec_prot = cfg_sec_prot; // RULE_01
    end
    if (tp_prot_we) begin
      s_d.prim_prot = tp_prim_prot; // RULE_04
      s_d.sec_prot = tp_sec_prot; // RULE_04
    end
    // Protection offsets are not decoded for writes, so they stay read-only
    if (reg_wr && addr[7:0] == MSP_OFS_SPACE_MAP) begin
      s_d.map = wdata & MSP_MAP_RW_MASK; // RULE_17 RULE_05
    end
    if (reg_rd) begin
      s_d.rvalid = 1'b1;
      unique case (addr[7:0])
        MSP_OFS_PRIM_PROT: s_d.rdata = {4'h0, s_q.prim_prot}; // RULE_11
        MSP_OFS_SEC_PROT: s_d.rdata = {security_flag, 5'h00, s_q.sec_prot}; // RULE_12
        MSP_OFS_SPACE_MAP: s_d.rdata = s_q.map;
        default: s_d.rdata = 8'h00;
      endcase
    end
    // Address and data hold until the next flash write
    if (fl_wr) begin
      s_d.cmd.addr = addr;
      s_d.cmd.data = wdata;
    end
    unique case (s_q.st)
      MSP_ST_IDLE, MSP_ST_UNLK1, MSP_ST_UNLK2, MSP_ST_PGM_DATA,
      MSP_ST_ERS1, MSP_ST_ERS2, MSP_ST_ERS3: begin
        if (fl_wr) begin
          s_d.st = MSP_ST_IDLE;
          if (rst_cmd) begin
            s_d.st = MSP_ST_IDLE; // RULE_06 RULE_08
          end else if (s_q.st == MSP_ST_IDLE) begin
            if (is_unlk(addr, wdata, MSP_UNLK_ADDR1, MSP_UNLK_DATA1)) begin
              s_d.st = MSP_ST_UNLK1;
            end
          end else if (s_q.st == MSP_ST_UNLK1) begin
            if (is_unlk(addr, wdata, MSP_UNLK_ADDR2, MSP_UNLK_DATA2)) begin
              s_d.st = MSP_ST_UNLK2;
            end
          end else if (s_q.st == MSP_ST_UNLK2) begin
            if (wdata == MSP_CMD_PGM) begin
              s_d.st = MSP_ST_PGM_DATA;
            end else if (wdata == MSP_CMD_ERASE) begin
              s_d.st = MSP_ST_ERS1;
            end
          end else if (s_q.st == MSP_ST_ERS1) begin
            if (is_unlk(addr, wdata, MSP_UNLK_ADDR1, MSP_UNLK_DATA1)) begin
              s_d.st = MSP_ST_ERS2;
            end
          end else if (s_q.st == MSP_ST_ERS2) begin
            if (is_unlk(addr, wdata, MSP_UNLK_ADDR2, MSP_UNLK_DATA2)) begin
              s_d.st = MSP_ST_ERS3;
            end
          end else if (s_q.st == MSP_ST_PGM_DATA) begin
            if (!prot_hit(tgt, s_q.prim_prot, s_q.sec_prot)) begin // RULE_02
              s_d.st = MSP_ST_BUSY_PGM;
              s_d.cmd.start = 1'b1;
              s_d.cmd.op = MSP_OP_PGM;
              s_d.cmd.prim = tgt.primary_sector_selects;
              s_d.cmd.sec = tgt.secondary_sector_selects;
            end
          end else if (wdata == MSP_CMD_SECT) begin
            if (!prot_hit(tgt, s_q.prim_prot, s_q.sec_prot)) begin // RULE_02
              s_d.st = MSP_ST_BUSY_SECT;
              s_d.cmd.start = 1'b1;
              s_d.cmd.op = MSP_OP_SECT;
              s_d.cmd.prim = tgt.primary_sector_selects;
              s_d.cmd.sec = tgt.secondary_sector_selects;
            end
          end else if (wdata == MSP_CMD_BULK) begin
            // Bulk erase covers only the unprotected sectors of the addressed array
            s_d.st = MSP_ST_BUSY_BULK;
            s_d.cmd.start = 1'b1;
            s_d.cmd.op = MSP_OP_BULK;
            s_d.cmd.prim = (|tgt.primary_sector_selects) ? ~s_q.prim_prot : '0; // RULE_01
            s_d.cmd.sec = (|tgt.secondary_sector_selects) ? ~s_q.sec_prot : '0; // RULE_01
          end
        end
        if (s_q.err && rst_cmd) begin
          s_d.st = MSP_ST_RECOVER; // RULE_08
        end
      end
      MSP_ST_BUSY_PGM, MSP_ST_BUSY_BULK: begin
        // Reset writes fall through here unseen
        if (fl_error) begin
          s_d.err = 1'b1;
          s_d.st = MSP_ST_IDLE;
        end else if (!fl_busy && !s_q.cmd.start) begin // RULE_09
          s_d.st = MSP_ST_IDLE;
        end
      end
      MSP_ST_BUSY_SECT: begin
        if (rst_cmd) begin
          s_d.st = MSP_ST_RECOVER; // RULE_10
        end else if (fl_error) begin
          s_d.err = 1'b1;
          s_d.st = MSP_ST_IDLE;
        end else if (!fl_busy && !s_q.cmd.start) begin
          s_d.st = MSP_ST_IDLE;
        end
      end
      MSP_ST_RECOVER: begin
        // The array core takes milliseconds; hold abort until it goes idle
        if (!fl_busy) begin
          s_d.st = MSP_ST_IDLE; // RULE_08 RULE_10
          s_d.err = 1'b0;
        end
      end
      default: s_d.st = MSP_ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '{st: MSP_ST_IDLE, cmd: '{op: MSP_OP_PGM, default: '0}, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ==================================================================
  // Outputs
  always_comb begin
    fl_cmd = s_q.cmd;
    fl_abort = (s_q.st == MSP_ST_RECOVER);
    fl_read_mode = !busy_st && !fl_abort && !s_q.err;
    reg_rdata = s_q.rdata;
    reg_rvalid = s_q.rvalid;
  end

  // ==================================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  a_prot_mcu_ro: assert property ( // RULE_05
    s_q.boot_done && !tp_prot_we |=> $stable(s_q.prim_prot) && $stable(s_q.sec_prot))
    else $error("protection changed without test port");
  a_tp_prot_load: assert property ( // RULE_04
    tp_prot_we |=> s_q.prim_prot == $past(tp_prim_prot) && s_q.sec_prot == $past(tp_sec_prot))
    else $error("test port protection write lost");
  a_prot_no_start: assert property ( // RULE_02
    fl_cmd.start && fl_cmd.op != MSP_OP_BULK |->
      !(|(fl_cmd.prim & s_q.prim_prot)) && !(|(fl_cmd.sec & s_q.sec_prot)))
    else $error("operation started on protected sector");
  a_bulk_skip_prot: assert property ( // RULE_01
    fl_cmd.start && fl_cmd.op == MSP_OP_BULK |->
      !(|(fl_cmd.prim & s_q.prim_prot)) && !(|(fl_cmd.sec & s_q.sec_prot)))
    else $error("bulk erase touches protected sector");
  a_reset_ignored: assert property ( // RULE_09
    s_q.st == MSP_ST_BUSY_PGM && rst_cmd && fl_busy && !fl_error |=> s_q.st == MSP_ST_BUSY_PGM)
    else $error("reset not ignored during program");
  a_sect_abort: assert property ( // RULE_10
    s_q.st == MSP_ST_BUSY_SECT && rst_cmd |=> fl_abort && !fl_read_mode)
    else $error("sector erase not aborted");
  a_abort_release: assert property ( // RULE_08
    fl_abort && !fl_busy |=> !fl_abort && fl_read_mode)
    else $error("abort did not return to read");
  a_reset_read: assert property ( // RULE_06
    fl_read_mode && rst_cmd |=> s_q.st == MSP_ST_IDLE && !fl_cmd.start)
    else $error("reset command did not return to read");
  a_prim_status: assert property ( // RULE_11
    reg_rd && addr[7:0] == MSP_OFS_PRIM_PROT |=> reg_rvalid && reg_rdata == {4'h0, $past(s_q.prim_prot)})
    else $error("primary status read wrong");
  a_sec_status: assert property ( // RULE_12
    reg_rd && addr[7:0] == MSP_OFS_SEC_PROT |=>
      reg_rdata[MSP_SEC_SECURITY] == $past(security_flag) && reg_rdata[1:0] == $past(s_q.sec_prot))
    else $error("secondary status read wrong");
  a_map_write: assert property ( // RULE_17
    reg_wr && addr[7:0] == MSP_OFS_SPACE_MAP && !tp_prot_we |=> s_q.map == ($past(wdata) & MSP_MAP_RW_MASK))
    else $error("space map write lost");
  a_sec_wins: assert property ( // RULE_15
    rd_stb && (|decode_sel.secondary_sector_selects) && s_q.map[MSP_MAP_SEC_DATA] &&
      !decode_sel.sram_select && !decode_sel.register_block_select && !decode_sel.pio_select
      |-> (|mem_en.secondary_sector_selects) && !(|mem_en.primary_sector_selects))
    else $error("secondary priority broken");
  a_top_wins: assert property ( // RULE_16
    decode_sel.sram_select |-> !(|mem_en.primary_sector_selects) && !(|mem_en.secondary_sector_selects))
    else $error("SRAM priority broken");
  a_sram_sel: assert property ( // RULE_13
    mem_en.sram_select |-> decode_sel.sram_select)
    else $error("SRAM enabled without select");
  a_combined: assert property ( // RULE_20
    s_q.map[MSP_MAP_PRIM_CODE] && s_q.map[MSP_MAP_PRIM_DATA] && (rd_stb || program_fetch_strobe) &&
      decode_sel == msp_sel_s'{primary_sector_selects: 4'h1, default: '0}
      |-> mem_en.primary_sector_selects == 4'h1)
    else $error("combined space not honoured");
  a_no_drive: assert property ( // RULE_21
    !rd_stb && !program_fetch_strobe |-> mem_en == '0)
    else $error("memory enabled without strobe");
  a_verify_read: assert property ( // RULE_03
    rd_stb && s_q.map[MSP_MAP_PRIM_DATA] &&
      decode_sel == msp_sel_s'{primary_sector_selects: 4'h1, default: '0}
      |-> mem_en.primary_sector_selects == 4'h1)
    else $error("protected sector not readable");

  c_pgm_done: cover property (s_q.st == MSP_ST_BUSY_PGM ##[1:20] s_q.st == MSP_ST_IDLE);
  c_sect_abort: cover property (s_q.st == MSP_ST_BUSY_SECT && rst_cmd);
  c_prot_drop: cover property (s_q.st == MSP_ST_PGM_DATA && fl_wr &&
    prot_hit(tgt, s_q.prim_prot, s_q.sec_prot));
  c_map_write: cover property (reg_wr && addr[7:0] == MSP_OFS_SPACE_MAP);

endmodule

// file: msp_flash_model.sv
// Behavioural model of the flash core behind the memory select controller
`timescale 1ns/1ps
module msp_flash_model
  import msp_pkg::*;
#(
  parameter int BUSY_LAT = 12
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire msp_pkg::msp_fcmd_s fl_cmd,
  input wire logic fl_abort,
  input wire logic err_mode,
  output logic fl_busy,
  output logic fl_error
);
  import msp_pkg::*;

  // ==================================================================
  // State
  typedef struct packed {
    logic busy;
    logic err;
    logic [7:0] cnt;
  } msp_fm_s;

  msp_fm_s st_q;
  msp_fm_s st_d;

  // ==================================================================
  // Busy and error sequencing
  always_comb begin
    st_d = st_q;
    if (fl_cmd.start) begin
      st_d.busy = 1'b1;
      st_d.cnt = BUSY_LAT[7:0];
    end else if (st_q.busy && fl_abort) begin
      st_d.busy = 1'b0;
    end else if (st_q.busy) begin
      // Error only when the bench asks for it, never on its own
      if (st_q.cnt == 8'h00) begin
        st_d.busy = 1'b0;
        st_d.err = err_mode;
      end else begin
        st_d.cnt = st_q.cnt - 8'h01;
      end
    end
    if (fl_abort) begin
      st_d.err = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign fl_busy = st_q.busy;
  assign fl_error = st_q.err;
endmodule

// file: msp_pkg.sv
// Shared types and constants of the memory select and protection controller
package msp_pkg;

  // ==================================================================
  // Register block offsets (low address byte within the register block)
  localparam logic [7:0] MSP_OFS_PRIM_PROT = 8'hc0;
  localparam logic [7:0] MSP_OFS_SEC_PROT = 8'hc2;
  localparam logic [7:0] MSP_OFS_SPACE_MAP = 8'hd2;

  // ==================================================================
  // Field positions
  localparam int MSP_PRIM_N = 4;
  localparam int MSP_SEC_N = 2;
  localparam int MSP_MAP_PIO = 7;
  localparam int MSP_MAP_PRIM_DATA = 4;
  localparam int MSP_MAP_SEC_DATA = 3;
  localparam int MSP_MAP_PRIM_CODE = 2;
  localparam int MSP_MAP_SEC_CODE = 1;
  localparam int MSP_MAP_SRAM_CODE = 0;
  localparam int MSP_SEC_SECURITY = 7;
  localparam logic [7:0] MSP_MAP_RW_MASK = 8'h9f;

  // ==================================================================
  // Flash command words and unlock addresses
  localparam logic [11:0] MSP_UNLK_ADDR1 = 12'h555;
  localparam logic [11:0] MSP_UNLK_ADDR2 = 12'haaa;
  localparam logic [7:0] MSP_UNLK_DATA1 = 8'haa;
  localparam logic [7:0] MSP_UNLK_DATA2 = 8'h55;
  localparam logic [7:0] MSP_CMD_PGM = 8'ha0;
  localparam logic [7:0] MSP_CMD_ERASE = 8'h80;
  localparam logic [7:0] MSP_CMD_SECT = 8'h30;
  localparam logic [7:0] MSP_CMD_BULK = 8'h10;
  localparam logic [7:0] MSP_CMD_RESET = 8'hf0;

  // ==================================================================
  // Types
  typedef struct packed {
    logic [MSP_PRIM_N-1:0] primary_sector_selects;
    logic [MSP_SEC_N-1:0] secondary_sector_selects;
    logic sram_select;
    logic register_block_select;
    logic pio_select;
  } msp_sel_s;

  typedef enum logic [2:0] {
    MSP_OP_PGM = 3'b001,
    MSP_OP_SECT = 3'b010,
    MSP_OP_BULK = 3'b100
  } msp_op_e;

  typedef enum logic [10:0] {
    MSP_ST_IDLE = 11'b000_0000_0001,
    MSP_ST_UNLK1 = 11'b000_0000_0010,
    MSP_ST_UNLK2 = 11'b000_0000_0100,
    MSP_ST_PGM_DATA = 11'b000_0000_1000,
    MSP_ST_ERS1 = 11'b000_0001_0000,
    MSP_ST_ERS2 = 11'b000_0010_0000,
    MSP_ST_ERS3 = 11'b000_0100_0000,
    MSP_ST_BUSY_PGM = 11'b000_1000_0000,
    MSP_ST_BUSY_BULK = 11'b001_0000_0000,
    MSP_ST_BUSY_SECT = 11'b010_0000_0000,
    MSP_ST_RECOVER = 11'b100_0000_0000
  } msp_state_e;

  typedef struct packed {
    logic start;
    msp_op_e op;
    logic [MSP_PRIM_N-1:0] prim;
    logic [MSP_SEC_N-1:0] sec;
    logic [15:0] addr;
    logic [7:0] data;
  } msp_fcmd_s;

  typedef struct packed {
    msp_state_e st;
    logic err;
    logic boot_done;
    logic [7:0] map;
    logic [MSP_PRIM_N-1:0] prim_prot;
    logic [MSP_SEC_N-1:0] sec_prot;
    logic [7:0] rdata;
    logic rvalid;
    msp_fcmd_s cmd;
  } msp_ctrl_s;

endpackage

// file: msp_route.sv
// Select priority and strobe gating for the memory components
`timescale 1ns/1ps
module msp_route
  import msp_pkg::*;
(
  input wire msp_pkg::msp_sel_s sel,
  input wire logic [7:0] space_map,
  input wire logic rd_stb,
  input wire logic program_fetch_strobe,
  output msp_pkg::msp_sel_s tgt,
  output msp_pkg::msp_sel_s mem_en
);
  import msp_pkg::*;

  // ==================================================================
  // Priority: register/SRAM/PIO over secondary over primary
  logic top_hit;
  logic sec_hit;

  always_comb begin
    top_hit = sel.sram_select | sel.register_block_select | sel.pio_select;
    sec_hit = |sel.secondary_sector_selects;
    tgt = sel;
    if (top_hit) begin
      tgt.primary_sector_selects = '0; // RULE_16
      tgt.secondary_sector_selects = '0; // RULE_16
    end else if (sec_hit) begin
      tgt.primary_sector_selects = '0; // RULE_15
    end
  end

  // ==================================================================
  // Strobe gating; a disabled winner leaves the bus undriven
  always_comb begin
    mem_en = '0;
    mem_en.sram_select = tgt.sram_select &
      (rd_stb | (program_fetch_strobe & space_map[MSP_MAP_SRAM_CODE])); // RULE_13 RULE_18
    mem_en.register_block_select = tgt.register_block_select & rd_stb; // RULE_21
    mem_en.pio_select = tgt.pio_select & rd_stb & space_map[MSP_MAP_PIO]; // RULE_18
    if ((rd_stb & space_map[MSP_MAP_PRIM_DATA]) |
        (program_fetch_strobe & space_map[MSP_MAP_PRIM_CODE])) begin
      mem_en.primary_sector_selects = tgt.primary_sector_selects; // RULE_20 RULE_03
    end
    if ((rd_stb & space_map[MSP_MAP_SEC_DATA]) |
        (program_fetch_strobe & space_map[MSP_MAP_SEC_CODE])) begin
      mem_en.secondary_sector_selects = tgt.secondary_sector_selects; // RULE_18
    end
  end

endmodule
